//--- hw/irc_mask_ctrl.sv
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
// Behaviour
// - write with bit 15 high sets every selected bit
// - write with bit 15 low clears every selected bit
// - unselected bits 14..0 keep their value
// - reads return stored bits 14..0, bit 15 reads zero
// - request and enable bits share positions per source
// - master enable low blocks every level
// - master enable bit never requests by itself
// - high external line low sets bit 13, level 6
// - low external line low sets bit 3, level 2
// - frame blank start sets bit 5, level 3
// - bit 4 belongs to coprocessor, set by write, level 3
// - bits 10..7 flag sound channels 3..0, level 4
// - sound done pulse supplied by channel for dma or manual mode
// - block copier done sets bit 6, level 3
// - disk pattern match sets bit 12, level 5
// - disk transfer done sets bit 1, level 1
// - receive buffer full sets bit 11, level 5
// - transmit buffer empty sets bit 0, level 1
// - set writes to requests behave as hardware sources
// - only levels 1 to 6 ever produced
// - request counts only while its enable bit is set
module irc_mask_ctrl
    import irc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // on-chip event pulses, same clock
    input wire logic frame_blank_evt,
    input wire logic block_copier_done_evt,
    input wire logic [3:0] sound_done_evt,
    input wire logic disk_pattern_match_evt,
    input wire logic disk_transfer_done_evt,
    input wire logic rx_full_evt,
    input wire logic tx_empty_evt,
    // external lines, asynchronous, active low
    input wire logic ext_low_irq_n,
    input wire logic ext_high_irq_n,
    // processor priority lines, active low
    output logic proc_priority_line_2_n,
    output logic proc_priority_line_1_n,
    output logic proc_priority_line_0_n
);

    // level of a single source position
    function automatic logic [2:0] irc_level(input int pos);
        case (pos)
            IRC_POS_HIGH_EXT: irc_level = 3'h6;
            IRC_POS_DISK_MATCH, IRC_POS_RX_FULL: irc_level = 3'h5;
            IRC_POS_FRAME, IRC_POS_COPIER, IRC_POS_COPROC: irc_level = 3'h3;
            IRC_POS_LOW_EXT: irc_level = 3'h2;
            IRC_POS_SOFT, IRC_POS_DISK_DONE, IRC_POS_TX_EMPTY: irc_level = 3'h1;
            default: begin
                if (pos >= IRC_POS_SOUND0 && pos <= IRC_POS_SOUND3) begin
                    irc_level = 3'h4;
                end else begin
                    irc_level = 3'h0; // master bit, no level
                end
            end
        endcase
    endfunction

    // selected bits changed by a write of the given polarity
    function automatic logic [14:0] irc_apply(input logic [14:0] cur, input logic [15:0] wd);
        if (wd[IRC_POS_POLARITY]) begin
            irc_apply = cur | wd[14:0];
        end else begin
            irc_apply = cur & ~wd[14:0];
        end
    endfunction

    logic [1:0] low_sync_q, low_sync_d;
    logic [1:0] high_sync_q, high_sync_d;
    logic [14:0] enable_q, enable_d;
    logic [14:0] request_q, request_d;
    logic [15:0] rdata_q, rdata_d;
    logic [2:0] ipl_n_q, ipl_n_d;
    logic [14:0] hw_set;
    logic [14:0] pending;

    // external lines cross into the clock domain through two flops
    always_comb begin
        low_sync_d = {low_sync_q[0], ext_low_irq_n};
        high_sync_d = {high_sync_q[0], ext_high_irq_n};
    end

    // hardware set sources; external lines are levels, so they re-set while held low
    always_comb begin
        hw_set = '0;
        hw_set[IRC_POS_HIGH_EXT] = ~high_sync_q[1];
        hw_set[IRC_POS_LOW_EXT] = ~low_sync_q[1];
        hw_set[IRC_POS_FRAME] = frame_blank_evt;
        hw_set[IRC_POS_SOUND3:IRC_POS_SOUND0] = sound_done_evt;
        hw_set[IRC_POS_COPIER] = block_copier_done_evt;
        hw_set[IRC_POS_DISK_MATCH] = disk_pattern_match_evt;
        hw_set[IRC_POS_DISK_DONE] = disk_transfer_done_evt;
        hw_set[IRC_POS_RX_FULL] = rx_full_evt;
        hw_set[IRC_POS_TX_EMPTY] = tx_empty_evt;
    end

    // register writes, then hardware sets on top so a set beats a same-cycle clear
    always_comb begin
        enable_d = enable_q;
        request_d = request_q;
        if (reg_wr && reg_addr == IRC_ADDR_ENABLE_WRITE) begin
            enable_d = irc_apply(enable_q, reg_wdata);
        end
        if (reg_wr && reg_addr == IRC_ADDR_REQUEST_WRITE) begin
            request_d = irc_apply(request_q, reg_wdata);
        end
        request_d = request_d | hw_set;
        request_d[IRC_POS_MASTER] = 1'b0;
    end

    // read port, data one cycle after the strobe; unmapped reads give zero
    always_comb begin
        rdata_d = 16'h0000;
        if (reg_rd && reg_addr == IRC_ADDR_ENABLE_READ) begin
            rdata_d = {1'b0, enable_q};
        end else if (reg_rd && reg_addr == IRC_ADDR_REQUEST_READ) begin
            rdata_d = {1'b0, request_q};
        end
    end

    // priority encode of enabled requests; bit 14 excluded so it never raises a level
    assign pending = request_q & enable_q & ~(15'h0001 << IRC_POS_MASTER);
    always_comb begin
        logic [2:0] lvl;
        lvl = 3'h0;
        for (int i = 0; i < 15; i++) begin
            if (pending[i] && irc_level(i) > lvl) begin
                lvl = irc_level(i);
            end
        end
        if (!enable_q[IRC_POS_MASTER]) begin
            lvl = 3'h0;
        end
        ipl_n_d = ~lvl;
    end

    // state registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_sync_q <= 2'h3;
            high_sync_q <= 2'h3;
            enable_q <= IRC_ENABLE_RST;
            request_q <= IRC_REQUEST_RST;
            rdata_q <= 16'h0000;
            ipl_n_q <= IRC_IPL_IDLE_N;
        end else begin
            low_sync_q <= low_sync_d;
            high_sync_q <= high_sync_d;
            enable_q <= enable_d;
            request_q <= request_d;
            rdata_q <= rdata_d;
            ipl_n_q <= ipl_n_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign proc_priority_line_2_n = ipl_n_q[2];
    assign proc_priority_line_1_n = ipl_n_q[1];
    assign proc_priority_line_0_n = ipl_n_q[0];

    // checks
    a_set_write_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_wr && reg_addr == IRC_ADDR_ENABLE_WRITE && reg_wdata[15]
        |=> ((enable_q & $past(reg_wdata[14:0])) == $past(reg_wdata[14:0])))
        else $error("set write did not set enable bits");
    a_clear_write_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_wr && reg_addr == IRC_ADDR_ENABLE_WRITE && !reg_wdata[15]
        |=> ((enable_q & $past(reg_wdata[14:0])) == 15'h0000))
        else $error("clear write did not clear enable bits");
    a_unselected_kept: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_wr && reg_addr == IRC_ADDR_ENABLE_WRITE
        |=> ((enable_q & ~$past(reg_wdata[14:0])) == ($past(enable_q) & ~$past(reg_wdata[14:0]))))
        else $error("unselected enable bit changed");
    a_read_enable: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_rd && reg_addr == IRC_ADDR_ENABLE_READ |=> reg_rdata == {1'b0, $past(enable_q)})
        else $error("enable read data wrong");
    a_master_blocks: assert property (@(posedge core_clk) disable iff (sys_rst)
        !enable_q[IRC_POS_MASTER] |=> ipl_n_q == 3'h7)
        else $error("level shown with master enable low");
    a_no_master_req: assert property (@(posedge core_clk) disable iff (sys_rst)
        !request_q[IRC_POS_MASTER])
        else $error("master bit became a request");
    a_high_ext_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        !ext_high_irq_n [*3] |=> request_q[IRC_POS_HIGH_EXT])
        else $error("high external line did not set flag");
    a_level_six: assert property (@(posedge core_clk) disable iff (sys_rst)
        enable_q[IRC_POS_MASTER] && pending[IRC_POS_HIGH_EXT] |=> ipl_n_q == 3'h1)
        else $error("high external not at level 6");
    a_frame_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        frame_blank_evt |=> request_q[IRC_POS_FRAME])
        else $error("frame blank flag lost");
    a_never_seven: assert property (@(posedge core_clk) disable iff (sys_rst)
        ipl_n_q != 3'h0)
        else $error("level 7 produced");
    a_idle_high: assert property (@(posedge core_clk) disable iff (sys_rst)
        pending == 15'h0000 |=> ipl_n_q == 3'h7)
        else $error("lines not idle with nothing pending");
    a_tx_level_one: assert property (@(posedge core_clk) disable iff (sys_rst)
        enable_q[IRC_POS_MASTER] && pending == 15'h0001 |=> ipl_n_q == 3'h6)
        else $error("transmit empty not at level 1");

    // request register writes; hardware sets are left out since they win over a clear
    a_req_set_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_wr && reg_addr == IRC_ADDR_REQUEST_WRITE && reg_wdata[IRC_POS_POLARITY]
        |=> ((request_q & $past(reg_wdata[14:0]) & ~(15'h0001 << IRC_POS_MASTER))
            == ($past(reg_wdata[14:0]) & ~(15'h0001 << IRC_POS_MASTER))))
        else $error("set write did not set request bits");
    a_req_clear_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_wr && reg_addr == IRC_ADDR_REQUEST_WRITE && !reg_wdata[IRC_POS_POLARITY]
        |=> ((request_q & $past(reg_wdata[14:0]) & ~$past(hw_set)) == 15'h0000))
        else $error("clear write did not clear request bits");
    a_req_unselected: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_wr && reg_addr == IRC_ADDR_REQUEST_WRITE
        |=> ((request_q & ~$past(reg_wdata[14:0]) & ~$past(hw_set))
            == ($past(request_q) & ~$past(reg_wdata[14:0]) & ~$past(hw_set))))
        else $error("unselected request bit changed");
    a_req_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(reg_wr && reg_addr == IRC_ADDR_REQUEST_WRITE) && hw_set == 15'h0000
        |=> $stable(request_q))
        else $error("request changed with no write and no event");
    a_enable_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(reg_wr && reg_addr == IRC_ADDR_ENABLE_WRITE)
        |=> $stable(enable_q))
        else $error("enable changed with no write");

    // read port; data stand for exactly one cycle, zero otherwise
    a_read_request: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_rd && reg_addr == IRC_ADDR_REQUEST_READ
        |=> reg_rdata == {1'b0, $past(request_q)})
        else $error("request read data wrong");
    a_read_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        !reg_rd
        |=> reg_rdata == 16'h0000)
        else $error("read data shown without a read");
    a_read_wr_addr: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_rd && (reg_addr == IRC_ADDR_ENABLE_WRITE || reg_addr == IRC_ADDR_REQUEST_WRITE)
        |=> reg_rdata == 16'h0000)
        else $error("read of a write address gave data");
    a_read_top_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_rdata[IRC_POS_POLARITY] == 1'b0)
        else $error("read data bit 15 set");

    // source flags; each event pulse must land in its own request bit
    a_low_ext_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        !ext_low_irq_n [*3]
        |=> request_q[IRC_POS_LOW_EXT])
        else $error("low external line did not set flag");
    a_sound_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        sound_done_evt != 4'h0
        |=> ((request_q[IRC_POS_SOUND3:IRC_POS_SOUND0] & $past(sound_done_evt)) == $past(sound_done_evt)))
        else $error("sound done flag lost");
    a_copier_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        block_copier_done_evt
        |=> request_q[IRC_POS_COPIER])
        else $error("block copier flag lost");
    a_match_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        disk_pattern_match_evt
        |=> request_q[IRC_POS_DISK_MATCH])
        else $error("disk pattern flag lost");
    a_disk_done_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        disk_transfer_done_evt
        |=> request_q[IRC_POS_DISK_DONE])
        else $error("disk transfer flag lost");
    a_rx_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        rx_full_evt
        |=> request_q[IRC_POS_RX_FULL])
        else $error("receive full flag lost");
    a_tx_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        tx_empty_evt
        |=> request_q[IRC_POS_TX_EMPTY])
        else $error("transmit empty flag lost");

    // write-only sources: no hardware path may raise them
    a_coproc_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_wr && reg_addr == IRC_ADDR_REQUEST_WRITE && reg_wdata[IRC_POS_POLARITY] && reg_wdata[IRC_POS_COPROC]
        |=> request_q[IRC_POS_COPROC])
        else $error("coprocessor flag not set by write");
    a_coproc_only: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(reg_wr && reg_addr == IRC_ADDR_REQUEST_WRITE) && !request_q[IRC_POS_COPROC]
        |=> !request_q[IRC_POS_COPROC])
        else $error("coprocessor flag rose without a write");
    a_soft_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_wr && reg_addr == IRC_ADDR_REQUEST_WRITE && reg_wdata[IRC_POS_POLARITY] && reg_wdata[IRC_POS_SOFT]
        |=> request_q[IRC_POS_SOFT])
        else $error("software flag not set by write");
    a_soft_only: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(reg_wr && reg_addr == IRC_ADDR_REQUEST_WRITE) && !request_q[IRC_POS_SOFT]
        |=> !request_q[IRC_POS_SOFT])
        else $error("software flag rose without a write");

    // level per priority group, checked with the higher groups empty
    a_level_five: assert property (@(posedge core_clk) disable iff (sys_rst)
        enable_q[IRC_POS_MASTER] && !pending[IRC_POS_HIGH_EXT]
            && (pending[IRC_POS_DISK_MATCH] || pending[IRC_POS_RX_FULL])
        |=> ipl_n_q == 3'h2)
        else $error("disk match or receive not at level 5");
    a_level_four: assert property (@(posedge core_clk) disable iff (sys_rst)
        enable_q[IRC_POS_MASTER] && pending[IRC_POS_HIGH_EXT:IRC_POS_RX_FULL] == 3'h0
            && pending[IRC_POS_SOUND3:IRC_POS_SOUND0] != 4'h0
        |=> ipl_n_q == 3'h3)
        else $error("sound done not at level 4");
    a_level_three: assert property (@(posedge core_clk) disable iff (sys_rst)
        enable_q[IRC_POS_MASTER] && pending[IRC_POS_HIGH_EXT:IRC_POS_SOUND0] == 7'h00
            && pending[IRC_POS_COPIER:IRC_POS_COPROC] != 3'h0
        |=> ipl_n_q == 3'h4)
        else $error("frame, copier or coprocessor not at level 3");
    a_level_two: assert property (@(posedge core_clk) disable iff (sys_rst)
        enable_q[IRC_POS_MASTER] && pending[IRC_POS_HIGH_EXT:IRC_POS_COPROC] == 10'h000
            && pending[IRC_POS_LOW_EXT]
        |=> ipl_n_q == 3'h5)
        else $error("low external not at level 2");
    a_level_one: assert property (@(posedge core_clk) disable iff (sys_rst)
        enable_q[IRC_POS_MASTER] && pending[IRC_POS_HIGH_EXT:IRC_POS_LOW_EXT] == 11'h000
            && pending[IRC_POS_SOFT:IRC_POS_TX_EMPTY] != 3'h0
        |=> ipl_n_q == 3'h6)
        else $error("level 1 group not at level 1");

    // masking: with every source enable low nothing may reach the lines
    a_all_masked: assert property (@(posedge core_clk) disable iff (sys_rst)
        enable_q[IRC_POS_HIGH_EXT:IRC_POS_TX_EMPTY] == 14'h0000
        |=> ipl_n_q == IRC_IPL_IDLE_N)
        else $error("level shown with every source masked");
    // lines only move after the registers that feed them have moved
    a_lines_stand: assert property (@(posedge core_clk) disable iff (sys_rst)
        $stable(request_q) && $stable(enable_q)
        |=> $stable(ipl_n_q))
        else $error("priority lines moved with no cause");

endmodule // irc_mask_ctrl

//--- hw/irc_pkg.sv
package irc_pkg;
    // register map (word offsets on the plain register port)
    localparam logic [1:0] IRC_ADDR_ENABLE_WRITE = 2'h0;
    localparam logic [1:0] IRC_ADDR_ENABLE_READ = 2'h1;
    localparam logic [1:0] IRC_ADDR_REQUEST_WRITE = 2'h2;
    localparam logic [1:0] IRC_ADDR_REQUEST_READ = 2'h3;
    // field positions
    localparam int IRC_POS_POLARITY = 15;
    localparam int IRC_POS_MASTER = 14;
    localparam int IRC_POS_HIGH_EXT = 13;
    localparam int IRC_POS_DISK_MATCH = 12;
    localparam int IRC_POS_RX_FULL = 11;
    localparam int IRC_POS_SOUND3 = 10;
    localparam int IRC_POS_SOUND0 = 7;
    localparam int IRC_POS_COPIER = 6;
    localparam int IRC_POS_FRAME = 5;
    localparam int IRC_POS_COPROC = 4;
    localparam int IRC_POS_LOW_EXT = 3;
    localparam int IRC_POS_SOFT = 2;
    localparam int IRC_POS_DISK_DONE = 1;
    localparam int IRC_POS_TX_EMPTY = 0;
    // reset values
    localparam logic [14:0] IRC_ENABLE_RST = 15'h0000;
    localparam logic [14:0] IRC_REQUEST_RST = 15'h0000;
    localparam logic [2:0] IRC_IPL_IDLE_N = 3'h7;
endpackage

//--- testbench/irc_host_model.sv
`timescale 1ns/1ns
// far side: the processor priority inputs, decoded back into a level
module irc_host_model (
    // priority lines from the block, active low
    input wire logic line_2_n,
    input wire logic line_1_n,
    input wire logic line_0_n,
    // level as the processor sees it, 0 means nothing pending
    output logic [2:0] level
);
    // the processor reads the inverted lines; all high must read as no request
    assign level = ~{line_2_n, line_1_n, line_0_n};
endmodule // irc_host_model

//--- testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top import irc_pkg::*;;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] evt = 16'h0000;
    logic ext_low_n = 1'b1;
    logic ext_high_n = 1'b1;
    logic l2_n, l1_n, l0_n;
    logic [2:0] level;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;

    // event pulses sit at the request bit position they should set
    irc_mask_ctrl uut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_blank_evt(evt[5]),
        .block_copier_done_evt(evt[6]), .sound_done_evt(evt[10:7]), .disk_pattern_match_evt(evt[12]),
        .disk_transfer_done_evt(evt[1]), .rx_full_evt(evt[11]), .tx_empty_evt(evt[0]),
        .ext_low_irq_n(ext_low_n), .ext_high_irq_n(ext_high_n), .proc_priority_line_2_n(l2_n),
        .proc_priority_line_1_n(l1_n), .proc_priority_line_0_n(l0_n));
    irc_host_model host (.line_2_n(l2_n), .line_1_n(l1_n), .line_0_n(l0_n), .level(level));

    always #25 core_clk = ~core_clk;

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    function automatic logic [2:0] lvl(input int b);
        case (b)
            13: lvl = 3'h6;
            12, 11: lvl = 3'h5;
            10, 9, 8, 7: lvl = 3'h4;
            6, 5, 4: lvl = 3'h3;
            3: lvl = 3'h2;
            default: lvl = 3'h1;
        endcase
    endfunction

    task automatic lvl_after(input int n, input logic [2:0] exp);
        repeat (n) @(posedge core_clk);
        #1;
        chk("level", {13'h0000, level}, {13'h0000, exp});
    endtask

    task automatic t_setclr();
        logic [15:0] d;
        lvl_after(1, 3'h0);
        rd_reg(IRC_ADDR_REQUEST_READ, d);
        chk("request_reset", d, 16'h0000);
        wr_reg(IRC_ADDR_ENABLE_WRITE, 16'hc001);
        rd_reg(IRC_ADDR_ENABLE_READ, d);
        chk("enable_set", d, 16'h4001);
        wr_reg(IRC_ADDR_ENABLE_WRITE, 16'h8006);
        rd_reg(IRC_ADDR_ENABLE_READ, d);
        chk("enable_keep", d, 16'h4007);
        wr_reg(IRC_ADDR_ENABLE_WRITE, 16'h0003);
        rd_reg(IRC_ADDR_ENABLE_READ, d);
        chk("enable_clear", d, 16'h4004);
        rd_reg(IRC_ADDR_ENABLE_WRITE, d);
        chk("read_of_write_addr", d, 16'h0000);
    endtask

    // one source at a time, everything enabled, then cleared by software
    task automatic t_source(input int b);
        logic [15:0] d;
        if (b == 2 || b == 4) begin
            wr_reg(IRC_ADDR_REQUEST_WRITE, 16'h8000 | (16'h0001 << b));
        end else begin
            @(posedge core_clk);
            evt <= 16'h0001 << b;
            ext_low_n <= (b != 3);
            ext_high_n <= (b != 13);
            @(posedge core_clk);
            evt <= 16'h0000;
            repeat (3) @(posedge core_clk);
            ext_low_n <= 1'b1;
            ext_high_n <= 1'b1;
        end
        lvl_after(4, lvl(b));
        rd_reg(IRC_ADDR_REQUEST_READ, d);
        chk("request_bit", d, 16'h0001 << b);
        wr_reg(IRC_ADDR_REQUEST_WRITE, 16'h7fff);
        lvl_after(3, 3'h0);
    endtask

    task automatic t_mask();
        logic [15:0] d;
        wr_reg(IRC_ADDR_REQUEST_WRITE, 16'ha001);
        wr_reg(IRC_ADDR_ENABLE_WRITE, 16'h7fff);
        wr_reg(IRC_ADDR_ENABLE_WRITE, 16'hc001);
        lvl_after(3, 3'h1);
        wr_reg(IRC_ADDR_ENABLE_WRITE, 16'h4000);
        lvl_after(3, 3'h0);
        wr_reg(IRC_ADDR_ENABLE_WRITE, 16'he000);
        lvl_after(3, 3'h6);
        wr_reg(IRC_ADDR_REQUEST_WRITE, 16'h7fff);
        wr_reg(IRC_ADDR_REQUEST_WRITE, 16'hc000);
        lvl_after(3, 3'h0);
        rd_reg(IRC_ADDR_REQUEST_READ, d);
        chk("request_master", d, 16'h0000);
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_setclr();
        wr_reg(IRC_ADDR_ENABLE_WRITE, 16'hffff);
        for (int b = 0; b < 14; b++) begin
            t_source(b);
        end
        t_mask();
        end_sim();
    end
endmodule // tb_top
